/* File: rtl/acss_top.sv */
/*
 * audio clock source select: control registers and the routing of sampled
 * clock sources to converter cores, internal and pll clocks, system clocks.
 * assumes: decoded control port, one access per strobe; slow clock pins.
 */
`timescale 1ns/1ns
`default_nettype none
module acss_top
    import acss_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       NRST_I,
    // register port
    input  wire logic [6:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    // clock source pins
    input  wire logic       CRYSTAL_INPUT_I,
    input  wire logic       MASTER_CLOCK_INPUT_I,
    input  wire logic       RATE_ONE_I,
    input  wire logic       RATE_TWO_I,
    input  wire logic       RATE_THREE_I,
    input  wire logic       RECOVERED_CLOCK_I,
    // routed clocks
    output logic            DAC_CORE_CLK_O,
    output logic            ADC_CORE_CLK_O,
    output logic            INTERNAL_CLK_ONE_O,
    output logic            INTERNAL_CLK_TWO_O,
    output logic            PLL_INTERNAL_CLOCK_ONE_O,
    output logic            PLL_INTERNAL_CLOCK_TWO_O,
    output logic            FIRST_PLL_REF_CLK_O,
    output logic            SECOND_PLL_REF_CLK_O,
    // system clock outputs
    output logic            SYSTEM_CLOCK_OUT_ONE_O,
    output logic            SYSTEM_CLOCK_OUT_TWO_O,
    output logic            SYSTEM_CLOCK_OUT_THREE_O,
    // receiver control
    output logic            RECEIVER_POWER_DOWN_O,
    output logic            RECEIVER_INPUT_LEVEL_SEL_O
);
`include "acss_defines.svh"

    // --------------------------------------------------------------------
    // decode helpers
    // --------------------------------------------------------------------
    // converter code to source index; 110 and 111 fall back to crystal
    function automatic logic [2:0] conv_index(input logic [2:0] code);
        return (code[2:1] == 2'h3) ? 3'h0 : code;
    endfunction

    // --------------------------------------------------------------------
    // registers
    // --------------------------------------------------------------------
    logic [7:0] pll_ctl_q, pll_ctl_d;
    logic [7:0] conv_q, conv_d;
    logic [7:0] tap_q, tap_d;
    logic [7:0] ref_q, ref_d;
    logic [7:0] out_en_q, out_en_d;
    logic [7:0] rdata_q, rdata_d;

    // reserved bits are stored as written so a read returns the last write
    always_comb begin
        pll_ctl_d = pll_ctl_q;
        conv_d    = conv_q;
        tap_d     = tap_q;
        ref_d     = ref_q;
        out_en_d  = out_en_q;
        rdata_d   = rdata_q;
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                `ACSS_ADDR_PLL_CTL: pll_ctl_d = REG_WDATA_I;
                `ACSS_ADDR_CONV:    conv_d    = REG_WDATA_I;
                `ACSS_ADDR_TAP:     tap_d     = REG_WDATA_I;
                `ACSS_ADDR_REF:     ref_d     = REG_WDATA_I;
                `ACSS_ADDR_OUT_EN:  out_en_d  = REG_WDATA_I;
                default:            ;
            endcase
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `ACSS_ADDR_PLL_CTL: rdata_d = pll_ctl_q;
                `ACSS_ADDR_CONV:    rdata_d = conv_q;
                `ACSS_ADDR_TAP:     rdata_d = tap_q;
                `ACSS_ADDR_REF:     rdata_d = ref_q;
                `ACSS_ADDR_OUT_EN:  rdata_d = out_en_q;
                default:            rdata_d = `ACSS_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pll_ctl_q <= `ACSS_RST_PLL_CTL;
            conv_q    <= `ACSS_RST_CONV;
            tap_q     <= `ACSS_RST_TAP;
            ref_q     <= `ACSS_RST_REF;
            out_en_q  <= `ACSS_RST_OUT_EN;
            rdata_q   <= `ACSS_RST_RDATA;
        end else begin
            pll_ctl_q <= pll_ctl_d;
            conv_q    <= conv_d;
            tap_q     <= tap_d;
            ref_q     <= ref_d;
            out_en_q  <= out_en_d;
            rdata_q   <= rdata_d;
        end
    end

    assign REG_RDATA_O                = rdata_q;
    assign RECEIVER_POWER_DOWN_O      = out_en_q[`ACSS_RXPD_BIT];
    assign RECEIVER_INPUT_LEVEL_SEL_O = out_en_q[`ACSS_RXLVL_BIT];

    // --------------------------------------------------------------------
    // source sampling and halved rates
    // --------------------------------------------------------------------
    // sampling at CLK_I only suits sources well below a quarter of its rate
    acss_src_s  src;
    logic [3:0] half_q, half_d;
    logic [3:0] prev_q;
    logic [3:0] div_in;

    acss_pin_sync #(
        .W (6)
    ) u_sync (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .pin_i  ({RECOVERED_CLOCK_I, RATE_THREE_I, RATE_TWO_I, RATE_ONE_I,
                  MASTER_CLOCK_INPUT_I, CRYSTAL_INPUT_I}),
        .val_o  (src)
    );

    assign div_in = {src.rx_rec, src.rate_three, src.rate_two, src.rate_one};

    // each halved clock toggles on a rising edge of its source
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            half_d[i] = half_q[i] ^ (div_in[i] & ~prev_q[i]);
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            half_q <= 4'h0;
            prev_q <= 4'h0;
        end else begin
            half_q <= half_d;
            prev_q <= div_in;
        end
    end

    // --------------------------------------------------------------------
    // pll taps and references
    // --------------------------------------------------------------------
    logic       pll_int_one, pll_int_two;
    logic [5:0] conv_src;
    logic [3:0] int_src;

    acss_glitchless_mux #(.N (2)) u_tap_one (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  ({half_q[0], src.rate_one}),
        .sel_i  (tap_q[`ACSS_TAP1_BIT]),
        .clk_o  (pll_int_one)
    );
    acss_glitchless_mux #(.N (4)) u_tap_two (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  ({half_q[2], src.rate_three, half_q[1], src.rate_two}),
        .sel_i  (tap_q[`ACSS_TAP2_MSB:`ACSS_TAP2_LSB]),
        .clk_o  (pll_int_two)
    );
    acss_glitchless_mux #(.N (2)) u_ref_one (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  ({src.master, src.crystal}),
        .sel_i  (ref_q[`ACSS_REF1_BIT]),
        .clk_o  (FIRST_PLL_REF_CLK_O)
    );
    acss_glitchless_mux #(.N (2)) u_ref_two (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  ({src.master, src.crystal}),
        .sel_i  (ref_q[`ACSS_REF2_BIT]),
        .clk_o  (SECOND_PLL_REF_CLK_O)
    );
    assign PLL_INTERNAL_CLOCK_ONE_O = pll_int_one;
    assign PLL_INTERNAL_CLOCK_TWO_O = pll_int_two;

    // --------------------------------------------------------------------
    // converter and internal clocks
    // --------------------------------------------------------------------
    assign int_src  = {pll_int_two, pll_int_one, src.master, src.crystal};
    assign conv_src = {half_q[3], src.rx_rec, int_src};

    logic [2:0] dac_idx, adc_idx;
    assign dac_idx = conv_index(conv_q[`ACSS_DAC_MSB:`ACSS_DAC_LSB]);
    assign adc_idx = conv_index(conv_q[`ACSS_ADC_MSB:`ACSS_ADC_LSB]);

    acss_glitchless_mux #(.N (6)) u_dac (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  (conv_src),
        .sel_i  (dac_idx),
        .clk_o  (DAC_CORE_CLK_O)
    );
    acss_glitchless_mux #(.N (6)) u_adc (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  (conv_src),
        .sel_i  (adc_idx),
        .clk_o  (ADC_CORE_CLK_O)
    );
    acss_glitchless_mux #(.N (4)) u_iclk_one (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  (int_src),
        .sel_i  (tap_q[`ACSS_INT_ONE_MSB:`ACSS_INT_ONE_LSB]),
        .clk_o  (INTERNAL_CLK_ONE_O)
    );
    acss_glitchless_mux #(.N (4)) u_iclk_two (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  (int_src),
        .sel_i  (conv_q[`ACSS_INT_TWO_MSB:`ACSS_INT_TWO_LSB]),
        .clk_o  (INTERNAL_CLK_TWO_O)
    );

    // --------------------------------------------------------------------
    // system clock outputs
    // --------------------------------------------------------------------
    // reserved route codes are treated as the pll block
    logic       sys3_src;
    logic       route_rx;
    logic [2:0] sys_src, sys_dis;
    logic [2:0] gate_q, gate_d;
    logic [2:0] sys_q, sys_d;

    assign route_rx = (pll_ctl_q[`ACSS_ROUTE_MSB:`ACSS_ROUTE_LSB] == `ACSS_ROUTE_RX);
    acss_glitchless_mux #(.N (2)) u_sys3 (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .src_i  ({src.rx_rec, pll_int_two}),
        .sel_i  (route_rx),
        .clk_o  (sys3_src)
    );

    assign sys_src = {pll_int_one, pll_int_two, sys3_src};
    assign sys_dis = {out_en_q[`ACSS_SYS1_BIT], out_en_q[`ACSS_SYS2_BIT],
                      out_en_q[`ACSS_SYS3_BIT]};

    // the gate moves only while its source is low, so no runt leaves the pin
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gate_d[i] = sys_src[i] ? gate_q[i] : ~sys_dis[i];
            sys_d[i]  = sys_src[i] & gate_q[i];
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            gate_q <= 3'h0;
            sys_q  <= 3'h0;
        end else begin
            gate_q <= gate_d;
            sys_q  <= sys_d;
        end
    end

    assign SYSTEM_CLOCK_OUT_ONE_O   = sys_q[2];
    assign SYSTEM_CLOCK_OUT_TWO_O   = sys_q[1];
    assign SYSTEM_CLOCK_OUT_THREE_O = sys_q[0];

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    reg_readback_a: assert property (REG_WR_I && REG_ADDR_I == `ACSS_ADDR_CONV
        ##1 REG_RD_I && REG_ADDR_I == `ACSS_ADDR_CONV && !REG_WR_I
        |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("control register did not read back its write");
    dac_fallback_a: assert property (conv_q[7:6] == 2'h3 |-> dac_idx == 3'h0)
        else $error("dac code 11x did not pick the crystal");
    adc_receiver_a: assert property (conv_q[4:2] == 3'h5 |-> adc_idx == 3'h5)
        else $error("adc code 101 did not pick the halved recovered clock");
    rx_power_a: assert property ($rose(REG_WR_I && REG_ADDR_I == `ACSS_ADDR_OUT_EN)
        |=> RECEIVER_POWER_DOWN_O == $past(REG_WDATA_I[5]))
        else $error("receiver power down did not follow its bit");
    rx_level_a: assert property (REG_WR_I && REG_ADDR_I == `ACSS_ADDR_OUT_EN
        |=> RECEIVER_INPUT_LEVEL_SEL_O == $past(REG_WDATA_I[4]))
        else $error("receiver level select did not follow its bit");
    sys_one_off_a: assert property (out_en_q[2] [*2] ##0 !sys_src[2]
        |=> !SYSTEM_CLOCK_OUT_ONE_O [*2])
        else $error("disabled system clock one still toggles");
    sys_two_off_a: assert property (out_en_q[1] [*2] ##0 !sys_src[1]
        |=> !SYSTEM_CLOCK_OUT_TWO_O [*2])
        else $error("disabled system clock two still toggles");
    sys_three_off_a: assert property (out_en_q[0] [*2] ##0 !sys_src[0]
        |=> !SYSTEM_CLOCK_OUT_THREE_O [*2])
        else $error("disabled system clock three still toggles");
    sys_gate_low_a: assert property ($changed(gate_q) |->
        (($past(gate_q) ^ gate_q) & $past(sys_src)) == 3'h0)
        else $error("system clock gate moved while its source was high");
    route_rx_a: assert property (pll_ctl_q[7:6] == 2'h3 |-> route_rx)
        else $error("route code 11 did not select the recovered clock");
    route_pll_a: assert property (pll_ctl_q[7:6] != 2'h3 |-> !route_rx)
        else $error("route code other than 11 left the pll block");
    ref_hold_a: assert property ($stable(ref_q) [*8] ##0 ref_q[7] && !src.master
        |=> !SECOND_PLL_REF_CLK_O)
        else $error("second pll reference does not follow master clock");
    ref_one_a: assert property ($stable(ref_q) [*8] ##0 !ref_q[6] && !src.crystal
        |=> !FIRST_PLL_REF_CLK_O)
        else $error("first pll reference does not follow crystal");

    dac_switch_c: cover property ($changed(conv_q[7:5]) ##[1:40] $rose(DAC_CORE_CLK_O));
    sys_disable_c: cover property ($rose(out_en_q[2]) ##[1:40] $fell(gate_q[2]));
    route_rx_c: cover property ($rose(route_rx) ##[1:40] $rose(SYSTEM_CLOCK_OUT_THREE_O));
endmodule
`default_nettype wire

/* File: rtl/acss_defines.svh */
/*
 * constants of the audio clock source select block: register offsets,
 * field positions and reset values.
 * assumes: included by bare name from the top module acss_top only.
 */
`ifndef ACSS_DEFINES_SVH
`define ACSS_DEFINES_SVH

// --------------------------------------------------------------------
// register offsets on the control port
// --------------------------------------------------------------------
`define ACSS_ADDR_PLL_CTL   7'h74
`define ACSS_ADDR_CONV      7'h76
`define ACSS_ADDR_TAP       7'h77
`define ACSS_ADDR_REF       7'h78
`define ACSS_ADDR_OUT_EN    7'h7a

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define ACSS_RST_PLL_CTL    8'h00
`define ACSS_RST_CONV       8'h00
`define ACSS_RST_TAP        8'h00
`define ACSS_RST_REF        8'h00
`define ACSS_RST_OUT_EN     8'h00
`define ACSS_RST_RDATA      8'h00

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define ACSS_DAC_MSB        7
`define ACSS_DAC_LSB        5
`define ACSS_ADC_MSB        4
`define ACSS_ADC_LSB        2
`define ACSS_INT_TWO_MSB    1
`define ACSS_INT_TWO_LSB    0
`define ACSS_INT_ONE_MSB    4
`define ACSS_INT_ONE_LSB    3
`define ACSS_TAP2_MSB       2
`define ACSS_TAP2_LSB       1
`define ACSS_TAP1_BIT       0
`define ACSS_REF2_BIT       7
`define ACSS_REF1_BIT       6
`define ACSS_RXPD_BIT       5
`define ACSS_RXLVL_BIT      4
`define ACSS_SYS1_BIT       2
`define ACSS_SYS2_BIT       1
`define ACSS_SYS3_BIT       0
`define ACSS_ROUTE_MSB      7
`define ACSS_ROUTE_LSB      6
`define ACSS_ROUTE_RX       2'h3

`endif

/* File: rtl/acss_pkg.sv */
/*
 * types of the audio clock source select block.
 * assumes: nothing beyond the defines header.
 */
package acss_pkg;

    // sampled clock sources, one bit each
    typedef struct packed {
        logic rx_rec;
        logic rate_three;
        logic rate_two;
        logic rate_one;
        logic master;
        logic crystal;
    } acss_src_s;

    typedef enum logic {ACSS_SW_RUN, ACSS_SW_PARK} acss_sw_e;

endpackage

/* File: rtl/acss_pin_sync.sv */
/*
 * three-flop input synchroniser; a change is taken once stages two and
 * three agree.
 * assumes: inputs asynchronous to clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module acss_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // pins and result
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] val_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, val_q;
    logic [W-1:0] val_d;

    always_comb begin
        val_d = (s3_q & ~(s2_q ^ s3_q)) | (val_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            val_q <= '0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            val_q <= val_d;
        end
    end

    assign val_o = val_q;

    sync_agree_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $changed(val_q) |-> (($past(val_q) ^ val_q) & ($past(s2_q) ^ $past(s3_q))) == '0)
        else $error("synchronised value changed without agreement");
endmodule
`default_nettype wire

/* File: rtl/acss_glitchless_mux.sv */
/*
 * glitch-free clock switch over sampled clocks: the old source is left
 * only while low, the output parks low, and the new source is joined
 * only while low, so no shortened phase reaches the output.
 * assumes: sources already synchronised to clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module acss_glitchless_mux
    import acss_pkg::*;
#(
    parameter int N  = 2,
    parameter int SW = (N > 1) ? $clog2(N) : 1
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // sources and selection
    input  wire logic [N-1:0]  src_i,
    input  wire logic [SW-1:0] sel_i,
    // switched clock
    output logic               clk_o
);
    acss_sw_e        state_q, state_d;
    logic [SW-1:0]   cur_q, cur_d;
    logic            clk_q, clk_d;

    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        clk_d   = clk_q;
        unique case (state_q)
            ACSS_SW_RUN: begin
                clk_d = src_i[cur_q];
                if (sel_i != cur_q && !src_i[cur_q]) begin
                    state_d = ACSS_SW_PARK;
                    cur_d   = sel_i;
                    clk_d   = 1'b0;
                end
            end
            ACSS_SW_PARK: begin
                clk_d = 1'b0;
                if (!src_i[cur_q]) begin
                    state_d = ACSS_SW_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ACSS_SW_RUN;
            cur_q   <= '0;
            clk_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            clk_q   <= clk_d;
        end
    end

    assign clk_o = clk_q;

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    handover_park_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == ACSS_SW_RUN && sel_i != cur_q && !src_i[cur_q])
        |=> state_q == ACSS_SW_PARK && !clk_o [*1] ##1 !clk_o)
        else $error("switch did not park low on handover");
    rise_cause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(clk_o) |-> $past(state_q) == ACSS_SW_RUN && $past(src_i[cur_q]))
        else $error("switched clock rose without its source");
    switch_seen_c: cover property (@(posedge clk_i) disable iff (!nrst_i)
        state_q == ACSS_SW_PARK ##1 state_q == ACSS_SW_RUN);
endmodule
`default_nettype wire

/* File: dv/acss_tb.sv */
/*
 * self-checking bench of the audio clock source select block.
 * assumes: source pins are slow clocks made here from CLK_I counts,
 * each with its own half period so a routed clock is known by width.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    logic [6:0]      addr = 7'h00;
    logic [7:0]      wdata = 8'h00;
    logic            wr_s = 1'b0;
    logic            rd_s = 1'b0;
    logic [5:0]      src = 6'h00;
    wire logic [7:0] rdata;
    wire logic [10:0] ck;
    wire logic [1:0] rx;
    int              cyc = 0;
    int              n_fail = 0;
    int              total_checks = 0;
    // half periods: crystal, master, rate one, two, three, recovered
    int              hs[6] = '{4, 5, 6, 7, 9, 11};

    acss_top u_dut (
        .CLK_I                      (clk),
        .NRST_I                     (nrst),
        .REG_ADDR_I                 (addr),
        .REG_WDATA_I                (wdata),
        .REG_WR_I                   (wr_s),
        .REG_RD_I                   (rd_s),
        .REG_RDATA_O                (rdata),
        .CRYSTAL_INPUT_I            (src[0]),
        .MASTER_CLOCK_INPUT_I       (src[1]),
        .RATE_ONE_I                 (src[2]),
        .RATE_TWO_I                 (src[3]),
        .RATE_THREE_I               (src[4]),
        .RECOVERED_CLOCK_I          (src[5]),
        .DAC_CORE_CLK_O             (ck[0]),
        .ADC_CORE_CLK_O             (ck[1]),
        .INTERNAL_CLK_ONE_O         (ck[2]),
        .INTERNAL_CLK_TWO_O         (ck[3]),
        .PLL_INTERNAL_CLOCK_ONE_O   (ck[4]),
        .PLL_INTERNAL_CLOCK_TWO_O   (ck[5]),
        .FIRST_PLL_REF_CLK_O        (ck[6]),
        .SECOND_PLL_REF_CLK_O       (ck[7]),
        .SYSTEM_CLOCK_OUT_ONE_O     (ck[8]),
        .SYSTEM_CLOCK_OUT_TWO_O     (ck[9]),
        .SYSTEM_CLOCK_OUT_THREE_O   (ck[10]),
        .RECEIVER_POWER_DOWN_O      (rx[1]),
        .RECEIVER_INPUT_LEVEL_SEL_O (rx[0])
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        #1;
        cyc++;
        for (int i = 0; i < 6; i++) begin
            src[i] = (cyc % (2 * hs[i])) < hs[i];
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        step;
        wr_s = 1'b0;
        step;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        addr = a;
        rd_s = 1'b1;
        step;
        rd_s = 1'b0;
        step;
        chk(rdata, e);
    endtask

    // width of one high phase of output i after settling; 0 = stays low
    task automatic m(input int i, input int h);
        int n;
        int k;
        n = 0;
        k = 0;
        repeat (80) step;
        if (h == 0) begin
            repeat (60) begin
                step;
                n += int'(ck[i] !== 1'b0);
            end
        end else begin
            while (ck[i] !== 1'b0 && k < 200) begin step; k++; end
            while (ck[i] !== 1'b1 && k < 200) begin step; k++; end
            while (ck[i] === 1'b1 && k < 200) begin step; k++; n++; end
        end
        if (k >= 200) begin
            n_fail++;
            give_verdict;
        end else begin
            chk(8'(n), 8'(h));
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [6:0] a[5] = '{7'h74, 7'h76, 7'h77, 7'h78, 7'h7a};
        foreach (a[j]) rd(a[j], 8'h00);
        wr(7'h79, 8'h5a);
        rd(7'h79, 8'h00);
        wr(7'h78, 8'hc0);
        rd(7'h78, 8'hc0);
        // write then read back to back on the converter select
        addr = 7'h76;
        wdata = 8'ha5;
        wr_s = 1'b1;
        step;
        wr_s = 1'b0;
        rd_s = 1'b1;
        step;
        rd_s = 1'b0;
        step;
        chk(rdata, 8'ha5);
        wr(7'h78, 8'h00);
    endtask

    task automatic t_conv;
        int e[8] = '{4, 5, 6, 7, 11, 22, 4, 4};
        for (int c = 0; c < 8; c++) begin
            wr(7'h76, {3'(c), 3'(c), 2'b00});
            m(0, e[c]);
            m(1, e[c]);
        end
    endtask

    task automatic t_iclk;
        for (int c = 0; c < 4; c++) begin
            wr(7'h76, {6'h00, 2'(c)});
            wr(7'h77, {3'b000, 2'(c), 3'b000});
            m(3, hs[c]);
            m(2, hs[c]);
        end
    endtask

    task automatic t_tap;
        int e[4] = '{7, 14, 9, 18};
        for (int c = 0; c < 4; c++) begin
            wr(7'h77, {5'h00, 2'(c), 1'b1});
            m(5, e[c]);
        end
        m(4, 12);
        wr(7'h77, 8'h00);
        m(4, 6);
    endtask

    task automatic t_ref;
        for (int c = 0; c < 4; c++) begin
            wr(7'h78, {2'(c), 6'h00});
            m(6, c[0] ? 5 : 4);
            m(7, c[1] ? 5 : 4);
        end
    endtask

    task automatic t_out;
        m(8, 6);
        m(9, 7);
        m(10, 7);
        wr(7'h74, 8'hc0);
        m(10, 11);
        wr(7'h74, 8'h00);
        m(10, 7);
        for (int b = 0; b < 3; b++) begin
            wr(7'h7a, 8'h01 << b);
            m(10 - b, 0);
        end
        wr(7'h7a, 8'h20);
        chk({6'h00, rx}, 8'h02);
        wr(7'h7a, 8'h10);
        chk({6'h00, rx}, 8'h01);
    endtask

    // selects change at awkward moments; no high phase may be cut short
    task automatic t_glitch;
        int run;
        int bad;
        logic [2:0] c[4] = '{3'h5, 3'h0, 3'h4, 3'h1};
        // the phase running at entry may be partial, so it never counts
        run = -32;
        bad = 0;
        for (int j = 0; j < 400; j++) begin
            // writes are driven inline so no cycle goes unsampled
            wr_s = (j % 37 == 0);
            addr = 7'h76;
            wdata = {c[(j / 37) % 4], 5'h00};
            step;
            if (ck[0] === 1'b1) run++;
            else begin
                if (run > 0 && run < 4) bad++;
                run = 0;
            end
        end
        chk(8'(bad), 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        step;
        t_regs;
        t_conv;
        t_iclk;
        t_tap;
        t_ref;
        t_out;
        t_glitch;
        give_verdict;
    end
endmodule
`default_nettype wire
